/* rcre_exec.sv */
/*
  Execution block for subroutine return and rotate-left-through-carry.
  Decodes the latched instruction word and runs it over four quarter phases.
  Assumes the instruction word is steady for the whole instruction cycle,
  the read data until the end of Q2, and that the core pops the stack when told to.
*/
// Behaviour
// - Return pops the stack and loads the popped head value into the PC.
// - Rotate shifts byte left; bit 7 to carry, old carry into bit 0.
// - Destination bit 0 writes working register, 1 writes the data byte.
// - Bank bit 0 uses access bank; 1 uses the bank pointer bank.
// - Bank bit 0, extended set on, address up to 95: indexed offset.
`timescale 1ns/1ps
module rcre_exec (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  // Instruction
  input  wire logic [15:0] I_INSTR,
  input  wire logic        I_EXT_SET_EN,
  // Core state inputs
  input  wire logic [20:0] I_STACK_HEAD_VALUE,
  input  wire logic [3:0]  I_BANK_POINTER,
  input  wire logic [11:0] I_INDEX_BASE,
  input  wire logic [7:0]  I_RD_DATA,
  input  wire logic        I_CARRY,
  // Phase and address outputs
  output logic [1:0]       O_PHASE,
  output logic [11:0]      O_DATA_ADDR,
  output logic             O_INDEXED,
  // Results
  output logic [20:0]      O_PC,
  output logic             O_STACK_POP,
  output logic [7:0]       O_WREG,
  output logic             O_WREG_WE,
  output logic [7:0]       O_WR_DATA,
  output logic             O_MEM_WE,
  output logic             O_CARRY,
  output logic             O_NEG,
  output logic             O_ZERO,
  output logic             O_FLAGS_WE
);

  typedef enum logic [1:0] {RCRE_IDLE, RCRE_ROT, RCRE_RET} rcre_op_t;

  logic [1:0]  phase;
  rcre_op_t    op;
  logic        dest_sel;
  logic        bank_sel;
  logic [7:0]  f_addr;
  logic [7:0]  operand_ff;
  logic [7:0]  nxt_result;
  logic        nxt_carry;
  logic [20:0] pc_ff;
  logic        pop_ff;
  logic [7:0]  wreg_ff;
  logic        wreg_we_ff;
  logic [7:0]  wr_data_ff;
  logic        mem_we_ff;
  logic        carry_ff;
  logic        neg_ff;
  logic        zero_ff;
  logic        flags_we_ff;
  logic [11:0] addr;
  logic        indexed;

  // ----------------------------------------------------------------------
  // Phase generation
  // ----------------------------------------------------------------------
  rcre_phase_gen u_phase (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .o_phase     (phase),
    .o_cycle_end ()
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Classifies the instruction word
  always_comb begin
    op = RCRE_IDLE;
    if (I_INSTR[rcre_pkg::OPC_HI_MSB:rcre_pkg::OPC_HI_LSB] == rcre_pkg::ROT_OPC_HI) begin
      op = RCRE_ROT;
    end else if ((I_INSTR & rcre_pkg::RET_OPC_MASK) == rcre_pkg::RET_OPC) begin
      op = RCRE_RET;
    end
  end

  assign dest_sel = I_INSTR[rcre_pkg::DEST_BIT];
  assign bank_sel = I_INSTR[rcre_pkg::BANK_BIT];
  assign f_addr   = I_INSTR[rcre_pkg::ADDR_MSB:0];

  // ----------------------------------------------------------------------
  // Operand addressing
  // ----------------------------------------------------------------------
  // Selects bank pointer, access bank or indexed offset
  always_comb begin
    indexed = 1'b0;
    if (bank_sel) begin
      addr = {I_BANK_POINTER, f_addr};
    end else if (I_EXT_SET_EN && (f_addr <= rcre_pkg::INDEX_LIMIT)) begin
      indexed = 1'b1;
      addr    = I_INDEX_BASE + {4'h0, f_addr};
    end else if (f_addr[rcre_pkg::BYTE_MSB]) begin
      addr = {rcre_pkg::ACCESS_BANK_HI, f_addr};
    end else begin
      addr = {rcre_pkg::ACCESS_BANK_LO, f_addr};
    end
  end

  assign O_DATA_ADDR = addr;
  assign O_INDEXED   = indexed;
  assign O_PHASE     = phase;

  // ----------------------------------------------------------------------
  // Operand read
  // ----------------------------------------------------------------------
  // Captures the addressed byte in Q2
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      operand_ff <= rcre_pkg::ZERO_BYTE;
    end else if (phase == rcre_pkg::PH_Q2 && op == RCRE_ROT) begin
      operand_ff <= I_RD_DATA;
    end
  end

  // ----------------------------------------------------------------------
  // Rotate datapath
  // ----------------------------------------------------------------------
  assign nxt_result = {operand_ff[rcre_pkg::BYTE_MSB-1:0], I_CARRY};
  assign nxt_carry  = operand_ff[rcre_pkg::BYTE_MSB];

  // ----------------------------------------------------------------------
  // Destination write in Q4
  // ----------------------------------------------------------------------
  // Pulses the selected write strobe for one clock
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wreg_ff    <= rcre_pkg::ZERO_BYTE;
      wreg_we_ff <= 1'b0;
      wr_data_ff <= rcre_pkg::ZERO_BYTE;
      mem_we_ff  <= 1'b0;
    end else begin
      wreg_we_ff <= 1'b0;
      mem_we_ff  <= 1'b0;
      if (phase == rcre_pkg::PH_Q3 && op == RCRE_ROT) begin
        if (dest_sel) begin
          wr_data_ff <= nxt_result;
          mem_we_ff  <= 1'b1;
        end else begin
          wreg_ff    <= nxt_result;
          wreg_we_ff <= 1'b1;
        end
      end
    end
  end

  // Updates carry, negative and zero in Q4
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      carry_ff    <= 1'b0;
      neg_ff      <= 1'b0;
      zero_ff     <= 1'b0;
      flags_we_ff <= 1'b0;
    end else begin
      flags_we_ff <= 1'b0;
      if (phase == rcre_pkg::PH_Q3 && op == RCRE_ROT) begin
        carry_ff    <= nxt_carry;
        neg_ff      <= nxt_result[rcre_pkg::BYTE_MSB];
        zero_ff     <= (nxt_result == rcre_pkg::ZERO_BYTE);
        flags_we_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Subroutine return
  // ----------------------------------------------------------------------
  // Pops the stack and loads the program counter in Q4
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pc_ff  <= rcre_pkg::PC_RESET;
      pop_ff <= 1'b0;
    end else begin
      pop_ff <= 1'b0;
      if (phase == rcre_pkg::PH_Q3 && op == RCRE_RET) begin
        pc_ff  <= I_STACK_HEAD_VALUE;
        pop_ff <= 1'b1;
      end
    end
  end

  assign O_PC        = pc_ff;
  assign O_STACK_POP = pop_ff;
  assign O_WREG      = wreg_ff;
  assign O_WREG_WE   = wreg_we_ff;
  assign O_WR_DATA   = wr_data_ff;
  assign O_MEM_WE    = mem_we_ff;
  assign O_CARRY     = carry_ff;
  assign O_NEG       = neg_ff;
  assign O_ZERO      = zero_ff;
  assign O_FLAGS_WE  = flags_we_ff;

endmodule

/* rcre_pkg.sv */
/*
  Package for the rotate-through-carry and subroutine-return execution block.
  Holds the opcode patterns, field positions, phase timing and address constants.
  Assumes it is compiled before the design modules that use it.
*/
package rcre_pkg;

  // ----------------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------------
  localparam logic [5:0]  ROT_OPC_HI    = 6'h0D;    // 0011 01 in bits 15:10
  localparam logic [15:0] RET_OPC       = 16'h0012; // 0000 0000 0001 001s with s cleared
  localparam logic [15:0] RET_OPC_MASK  = 16'hFFFE; // Ignores the shadow bit
  localparam int          OPC_HI_MSB    = 15;
  localparam int          OPC_HI_LSB    = 10;
  localparam int          DEST_BIT      = 9;
  localparam int          BANK_BIT      = 8;
  localparam int          ADDR_MSB      = 7;
  localparam int          BYTE_MSB      = 7;

  // ----------------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;   // Offsets at or below go indexed
  localparam logic [3:0]  ACCESS_BANK_LO = 4'h0;   // Low half of access bank
  localparam logic [3:0]  ACCESS_BANK_HI = 4'hF;   // High half of access bank
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [20:0] PC_RESET      = 21'h000000;
  localparam int          PC_W          = 21;
  localparam int          DADDR_W       = 12;

  // ----------------------------------------------------------------------
  // Quarter phases
  // ----------------------------------------------------------------------
  localparam logic [1:0]  PH_Q1 = 2'h0;
  localparam logic [1:0]  PH_Q2 = 2'h1;
  localparam logic [1:0]  PH_Q3 = 2'h2;
  localparam logic [1:0]  PH_Q4 = 2'h3;
  localparam logic [1:0]  PH_LAST = 2'h3;

endpackage

/* rcre_phase_gen.sv */
/*
  Quarter-phase generator: divides the system clock into four quarter phases, output as a 2-bit count.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module rcre_phase_gen (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Phase outputs
  output logic [1:0]      o_phase,
  output logic            o_cycle_end
);

  logic [1:0] phase_ff;

  // ----------------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------------
  // Wraps Q4 to Q1 each instruction cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_ff <= rcre_pkg::PH_Q1;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  assign o_phase     = phase_ff;
  assign o_cycle_end = (phase_ff == rcre_pkg::PH_LAST);

endmodule

/* rcre_exec_monitor.sv */
/* Assertion checker for rcre_exec.
   Assumes rcre_pkg is compiled first; bound to the design's ports. */
`timescale 1ns/1ps
module rcre_exec_monitor (
  // Inputs
  input wire logic        I_CLK,
  input wire logic        I_RSTN,
  input wire logic [15:0] I_INSTR,
  input wire logic        I_EXT_SET_EN,
  input wire logic [20:0] I_STACK_HEAD_VALUE,
  input wire logic [3:0]  I_BANK_POINTER,
  input wire logic [11:0] I_INDEX_BASE,
  input wire logic [7:0]  I_RD_DATA,
  input wire logic        I_CARRY,
  // Outputs
  input wire logic [1:0]  O_PHASE,
  input wire logic [11:0] O_DATA_ADDR,
  input wire logic        O_INDEXED,
  input wire logic [20:0] O_PC,
  input wire logic        O_STACK_POP,
  input wire logic [7:0]  O_WREG,
  input wire logic        O_WREG_WE,
  input wire logic [7:0]  O_WR_DATA,
  input wire logic        O_MEM_WE,
  input wire logic        O_CARRY,
  input wire logic        O_NEG,
  input wire logic        O_ZERO,
  input wire logic        O_FLAGS_WE
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic [7:0] rd_ff;
  logic [7:0] rd_prev_ff;
  logic       c_ff;
  wire logic  is_rot = I_INSTR[15:10] == rcre_pkg::ROT_OPC_HI;
  wire logic  is_ret = (I_INSTR & rcre_pkg::RET_OPC_MASK) == rcre_pkg::RET_OPC;
  wire logic  q4     = O_PHASE == rcre_pkg::PH_Q4;
  wire logic  strobe = O_WREG_WE | O_MEM_WE | O_FLAGS_WE | O_STACK_POP;
  wire logic [7:0] res = {rd_prev_ff[6:0], c_ff};
  // Read data as taken at the end of Q2, carry as taken at the end of Q3
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_ff      <= 8'h00;
      rd_prev_ff <= 8'h00;
      c_ff       <= 1'b0;
    end else begin
      rd_ff      <= I_RD_DATA;
      rd_prev_ff <= rd_ff;
      c_ff       <= I_CARRY;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  chk_pop_loads_pc: assert property (q4 && is_ret |-> O_STACK_POP &&
    O_PC == $past(I_STACK_HEAD_VALUE)) else $error("return did not load pc");
  chk_rot_result: assert property (q4 && is_rot |-> O_CARRY == rd_prev_ff[7] &&
    (I_INSTR[9] ? O_WR_DATA : O_WREG) == res) else $error("bad rotate result");
  chk_dest_select: assert property (q4 && is_rot |-> O_WREG_WE == !I_INSTR[9] &&
    O_MEM_WE == I_INSTR[9]) else $error("wrong destination");
  chk_bank_select: assert property (is_rot && I_INSTR[8] |-> !O_INDEXED &&
    O_DATA_ADDR == {I_BANK_POINTER, I_INSTR[7:0]}) else $error("bad banked address");
  chk_index_offset: assert property (is_rot && !I_INSTR[8] && I_EXT_SET_EN &&
    I_INSTR[7:0] <= rcre_pkg::INDEX_LIMIT |-> O_INDEXED &&
    O_DATA_ADDR == I_INDEX_BASE + {4'h0, I_INSTR[7:0]}) else $error("bad indexed address");
  chk_flag_values: assert property (q4 && is_rot |-> O_FLAGS_WE && O_NEG == res[7] &&
    O_ZERO == (res == 8'h00)) else $error("bad flags");
  chk_strobe_timing: assert property (strobe |-> q4 && (is_rot || is_ret) ##1 !strobe)
    else $error("strobe out of place");
  chk_phase_advance: assert property (1'b1 |=> O_PHASE == 2'($past(O_PHASE) + 2'h1))
    else $error("phase did not advance");
  cover property (q4 && O_MEM_WE);
  cover property (is_rot && O_INDEXED);
  cover property (O_STACK_POP && I_INSTR[0]);
endmodule

bind rcre_exec rcre_exec_monitor u_mon (
  .I_CLK              (I_CLK),
  .I_RSTN             (I_RSTN),
  .I_INSTR            (I_INSTR),
  .I_EXT_SET_EN       (I_EXT_SET_EN),
  .I_STACK_HEAD_VALUE (I_STACK_HEAD_VALUE),
  .I_BANK_POINTER     (I_BANK_POINTER),
  .I_INDEX_BASE       (I_INDEX_BASE),
  .I_RD_DATA          (I_RD_DATA),
  .I_CARRY            (I_CARRY),
  .O_PHASE            (O_PHASE),
  .O_DATA_ADDR        (O_DATA_ADDR),
  .O_INDEXED          (O_INDEXED),
  .O_PC               (O_PC),
  .O_STACK_POP        (O_STACK_POP),
  .O_WREG             (O_WREG),
  .O_WREG_WE          (O_WREG_WE),
  .O_WR_DATA          (O_WR_DATA),
  .O_MEM_WE           (O_MEM_WE),
  .O_CARRY            (O_CARRY),
  .O_NEG              (O_NEG),
  .O_ZERO             (O_ZERO),
  .O_FLAGS_WE         (O_FLAGS_WE)
);

/* rotate_carry_return_exec_test.sv */
/* Self-checking bench for rcre_exec: random and corner instructions.
   Assumes rcre_pkg and rcre_exec are compiled first. */
`timescale 1ns/1ps
module rotate_carry_return_exec_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic I_CLK = 1'b0, I_RSTN = 1'b0, I_EXT_SET_EN = 1'b0, I_CARRY = 1'b0;
  logic [15:0] I_INSTR = 16'h0000;
  logic [20:0] I_STACK_HEAD_VALUE = 21'h000000, O_PC, pc_ref;
  logic [3:0]  I_BANK_POINTER = 4'h0;
  logic [11:0] I_INDEX_BASE = 12'h000, O_DATA_ADDR;
  logic [7:0]  I_RD_DATA = 8'h00, O_WREG, O_WR_DATA;
  logic [1:0]  O_PHASE;
  logic O_INDEXED, O_STACK_POP, O_WREG_WE, O_MEM_WE, O_CARRY, O_NEG, O_ZERO, O_FLAGS_WE;
  int   miscompares = 0, comparisons = 0;
  logic [15:0] cw [8] = '{16'h3612, 16'h3580, 16'h345F, 16'h3460, 16'h3480,
                          16'h0013, 16'h0012, 16'h3000};
  rcre_exec dut (
    .I_CLK              (I_CLK),
    .I_RSTN             (I_RSTN),
    .I_INSTR            (I_INSTR),
    .I_EXT_SET_EN       (I_EXT_SET_EN),
    .I_STACK_HEAD_VALUE (I_STACK_HEAD_VALUE),
    .I_BANK_POINTER     (I_BANK_POINTER),
    .I_INDEX_BASE       (I_INDEX_BASE),
    .I_RD_DATA          (I_RD_DATA),
    .I_CARRY            (I_CARRY),
    .O_PHASE            (O_PHASE),
    .O_DATA_ADDR        (O_DATA_ADDR),
    .O_INDEXED          (O_INDEXED),
    .O_PC               (O_PC),
    .O_STACK_POP        (O_STACK_POP),
    .O_WREG             (O_WREG),
    .O_WREG_WE          (O_WREG_WE),
    .O_WR_DATA          (O_WR_DATA),
    .O_MEM_WE           (O_MEM_WE),
    .O_CARRY            (O_CARRY),
    .O_NEG              (O_NEG),
    .O_ZERO             (O_ZERO),
    .O_FLAGS_WE         (O_FLAGS_WE)
  );
  // Clock of 40 ns
  initial forever #20 I_CLK = ~I_CLK;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Operand address expected from the fields
  function automatic logic [11:0] exp_addr(logic [15:0] w, logic e);
    if (w[8]) return {I_BANK_POINTER, w[7:0]};
    if (e && w[7:0] <= 8'h5F) return I_INDEX_BASE + {4'h0, w[7:0]};
    return {(w[7] ? 4'hF : 4'h0), w[7:0]};
  endfunction
  // One instruction cycle, started at Q1 and checked in Q4
  task automatic run_op(input logic [15:0] w, input logic [7:0] d, input logic c, input logic e);
    int n;
    logic rot, ret;
    logic [7:0] r;
    n = 0;
    @(negedge I_CLK);
    while (O_PHASE !== 2'h0 && n < 8) begin
      @(negedge I_CLK);
      n++;
    end
    if (n >= 8) begin
      miscompares++;
      tally_and_finish();
    end
    rot = w[15:10] == 6'h0D;
    ret = w[15:1] == 15'h0009;
    r = {d[6:0], c};
    I_INSTR = w;
    I_RD_DATA = d;
    I_CARRY = c;
    I_EXT_SET_EN = e;
    I_STACK_HEAD_VALUE = 21'($urandom);
    I_BANK_POINTER = 4'($urandom);
    I_INDEX_BASE = 12'($urandom);
    #1;
    if (rot) chk(O_DATA_ADDR === exp_addr(w, e), "address");
    if (rot) chk(O_INDEXED === (!w[8] && e && w[7:0] <= 8'h5F), "indexed flag");
    // Read data is spoilt after Q2 to prove the operand was taken at the end of Q2
    repeat (2) @(negedge I_CLK);
    I_RD_DATA = ~d;
    @(negedge I_CLK);
    chk(O_FLAGS_WE === rot && O_WREG_WE === (rot & !w[9]) && O_MEM_WE === (rot & w[9])
        && O_STACK_POP === ret, "strobes");
    if (rot) chk((w[9] ? O_WR_DATA : O_WREG) === r && O_CARRY === d[7], "rotate");
    if (rot) chk(O_NEG === r[7] && O_ZERO === (r == 8'h00), "flags");
    if (ret) pc_ref = I_STACK_HEAD_VALUE;
    chk(O_PC === pc_ref, "pc");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] w;
    void'($urandom(28));
    pc_ref = 21'h000000;
    repeat (6) @(negedge I_CLK);
    I_RSTN = 1'b1;
    for (int i = 0; i < 8; i++) run_op(cw[i], (i == 1) ? 8'h80 : 8'hE6, 1'b0, 1'b1);
    for (int k = 0; k < 120; k++) begin
      case ($urandom % 4)
        0, 1:    w = {6'h0D, 10'($urandom)};
        2:       w = 16'h0012 | 16'($urandom % 2);
        default: w = 16'($urandom);
      endcase
      run_op(w, 8'($urandom), 1'($urandom), 1'($urandom));
      if (k == 60) begin
        // No-op word so that nothing runs in the cycle after release
        @(negedge I_CLK);
        I_INSTR = 16'h0000;
        I_RSTN = 1'b0;
        @(negedge I_CLK);
        chk(O_PC === 21'h000000 && O_PHASE === 2'h0 && O_STACK_POP === 1'b0
            && O_FLAGS_WE === 1'b0 && O_WREG === 8'h00, "reset");
        I_RSTN = 1'b1;
        pc_ref = 21'h000000;
      end
    end
    tally_and_finish();
  end
endmodule
